/* bench/lsiu_core_props.sv */
// lsiu_core_props: port-level timing checks of the load/store unit
`timescale 1ns/10ps
`default_nettype none
module lsiu_core_props
	import lsiu_pkg::*;
(
	input wire logic			clk_i,
	input wire logic			rst_i,
	input wire logic			instr_valid_i,
	input wire lsiu_instr_t			instr_i,
	input wire logic			ready_o,
	input wire logic			done_o,
	input wire logic			illegal_o,
	input wire logic [7:0]			page_i,
	input wire logic [15:0]			sp_o,
	input wire logic			dm_rd_o,
	input wire logic			dm_wr_o,
	input wire logic [ADDR_W-1:0]		dm_addr_o,
	input wire logic			pm_rd_o,
	input wire logic			pm_wr_o,
	input wire logic [PM_ADDR_W-1:0]	pm_addr_o,
	input wire logic			pm_ack_i,
	input wire logic			io_wr_o,
	input wire logic [IO_ADDR_W-1:0]	io_addr_o
);
	// ------
	// checks
	// ------
	logic		take;
	lsiu_kind_t	kd;
	lsiu_mode_t	md;
	assign take = instr_valid_i && ready_o;
	assign kd = instr_i.kind;
	assign md = instr_i.mode;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	AST_LD_ONE: assert property (
		take && kd == K_LOAD && md inside {M_PLAIN, M_POSTINC}
		|=> dm_rd_o && !ready_o ##1 done_o && ready_o && !dm_rd_o)
		else $error("one-clock load timing wrong");
	AST_LD_PREDEC: assert property (
		take && kd == K_LOAD && md == M_PREDEC
		|=> !dm_rd_o ##1 dm_rd_o ##1 done_o)
		else $error("pre-decrement load timing wrong");
	AST_DISP_X: assert property (
		take && kd inside {K_LOAD, K_STORE} && md == M_DISP && instr_i.ptr == P_X
		|=> illegal_o && ready_o && !dm_rd_o && !dm_wr_o)
		else $error("displacement via first pointer accepted");
	AST_DIRECT_ST: assert property (
		take && kd == K_DIRECT_ST
		|-> ##2 dm_wr_o && dm_addr_o == $past(instr_i.imm, 2))
		else $error("direct store wrong");
	AST_PM_LD_EX: assert property (
		take && kd == K_PM_LOAD_EX && md inside {M_PLAIN, M_POSTINC}
		|-> ##3 pm_rd_o && pm_addr_o[23:16] == $past(page_i, 3))
		else $error("extended program load wrong");
	AST_PM_LD: assert property (
		take && kd == K_PM_LOAD && md inside {M_PLAIN, M_POSTINC}
		|-> ##3 pm_rd_o && pm_addr_o[23:16] == PM_PAGE_ZERO ##1 done_o)
		else $error("program load wrong");
	AST_SPM_HOLD: assert property (
		pm_wr_o && !pm_ack_i |=> pm_wr_o)
		else $error("program store dropped early");
	AST_SPM_END: assert property (
		pm_wr_o && pm_ack_i |=> !pm_wr_o && done_o)
		else $error("program store not ended");
	AST_IO_OUT: assert property (
		take && kd == K_IO_OUT
		|=> io_wr_o && io_addr_o == $past(instr_i.io_addr) ##1 done_o)
		else $error("output to io wrong");
	AST_PUSH: assert property (
		take && kd == K_PUSH |=> dm_wr_o && dm_addr_o == $past(sp_o))
		else $error("push wrong");
	AST_POP: assert property (
		take && kd == K_POP
		|=> !dm_rd_o ##1 dm_rd_o && dm_addr_o == sp_o ##1 done_o)
		else $error("pop wrong");
	COV_SPM_WAIT: cover property (pm_wr_o && !pm_ack_i ##1 pm_ack_i);
	COV_REFUSED: cover property (illegal_o);
	COV_BACK2BACK: cover property (done_o && take);
endmodule // lsiu_core_props
bind lsiu_core lsiu_core_props lsiu_core_props_inst (.clk_i, .rst_i,
	.instr_valid_i, .instr_i, .ready_o, .done_o, .illegal_o, .page_i, .sp_o,
	.dm_rd_o, .dm_wr_o, .dm_addr_o, .pm_rd_o, .pm_wr_o, .pm_addr_o,
	.pm_ack_i, .io_wr_o, .io_addr_o);
`default_nettype wire

/* bench/lsiu_core_tb_top.sv */
// lsiu_core_tb_top: self-checking bench of the load/store unit
`timescale 1ns/10ps
`default_nettype none
module lsiu_core_tb_top;
	import lsiu_pkg::*;
	logic			clk_i = 1'b0;
	logic			rst_i = 1'b1;
	logic			instr_valid_i, reg_we_i, ready_o, done_o, illegal_o;
	logic			dm_rd_o, dm_wr_o, pm_rd_o, pm_wr_o, pm_ack_i, io_rd_o, io_wr_o;
	lsiu_instr_t		instr_i;
	logic [4:0]		reg_waddr_i, reg_raddr_i;
	logic [7:0]		page_i, reg_wdata_i, reg_rdata_o, dm_wdata_o, dm_rdata_i;
	logic [7:0]		pm_rdata_i, io_wdata_o, io_rdata_i;
	logic [15:0]		sp_o, pm_wdata_o, dm_addr_o, spm_d;
	logic [PM_ADDR_W-1:0]	pm_addr_o, spm_a;
	logic [IO_ADDR_W-1:0]	io_addr_o;
	logic [3:0]		ack_dly;
	int			bad_count = 0;
	int			checks = 0;
	always #10 clk_i = ~clk_i;
	lsiu_core lsiu_core_inst (.clk_i, .rst_i, .instr_valid_i, .instr_i,
		.ready_o, .done_o, .illegal_o, .page_i, .reg_we_i, .reg_waddr_i,
		.reg_wdata_i, .reg_raddr_i, .reg_rdata_o, .sp_o, .dm_rd_o, .dm_wr_o,
		.dm_addr_o, .dm_wdata_o, .dm_rdata_i, .pm_rd_o, .pm_wr_o, .pm_addr_o,
		.pm_wdata_o, .pm_rdata_i, .pm_ack_i, .io_rd_o, .io_wr_o, .io_addr_o,
		.io_wdata_o, .io_rdata_i);
	lsiu_mem_model lsiu_mem_model_inst (.clk_i, .dm_rd_i(dm_rd_o),
		.dm_wr_i(dm_wr_o), .dm_addr_i(dm_addr_o), .dm_wdata_i(dm_wdata_o),
		.dm_rdata_o(dm_rdata_i), .pm_rd_i(pm_rd_o), .pm_wr_i(pm_wr_o),
		.pm_addr_i(pm_addr_o), .pm_rdata_o(pm_rdata_i), .pm_ack_o(pm_ack_i),
		.ack_dly_i(ack_dly), .io_rd_i(io_rd_o), .io_wr_i(io_wr_o),
		.io_addr_i(io_addr_o), .io_wdata_i(io_wdata_o), .io_rdata_o(io_rdata_i));
	task automatic chk(input string nm, input logic [23:0] e, g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wreg(input logic [4:0] r, input logic [7:0] v);
		reg_we_i = 1'b1;
		reg_waddr_i = r;
		reg_wdata_i = v;
		@(posedge clk_i);
		#1;
		reg_we_i = 1'b0;
		// an edge passes so a following write raises the strobe afresh
		@(posedge clk_i);
		#1;
	endtask
	task automatic rreg(input logic [4:0] r, output logic [7:0] v);
		reg_raddr_i = r;
		repeat (2) @(posedge clk_i);
		#1;
		v = reg_rdata_o;
	endtask
	task automatic setp(input logic [4:0] lo, input logic [15:0] v);
		wreg(lo, v[7:0]);
		wreg(lo + 5'h01, v[15:8]);
	endtask
	task automatic getp(input logic [4:0] lo, input logic [15:0] e);
		logic [15:0] v;
		rreg(lo + 5'h01, v[15:8]);
		rreg(lo, v[7:0]);
		chk("pointer", e, v);
	endtask
	function automatic lsiu_instr_t mk(lsiu_kind_t k, lsiu_mode_t m,
		lsiu_ptr_t p, logic [4:0] r, logic [15:0] imm);
		mk = '0;
		mk.kind = k;
		mk.mode = m;
		mk.ptr = p;
		mk.has_reg = 1'b1;
		mk.regno = r;
		mk.imm = imm;
		mk.disp = imm[5:0];
		mk.io_addr = imm[5:0];
	endfunction
	// n is the busy length, 0 where the partner sets the pace
	task automatic run(input lsiu_instr_t i, input int n, input string nm);
		int c;
		instr_i = i;
		instr_valid_i = 1'b1;
		@(posedge clk_i);
		#1;
		instr_valid_i = 1'b0;
		c = 1;
		while (done_o !== 1'b1 && c < 40) begin
			if (pm_wr_o === 1'b1) begin
				spm_a = pm_addr_o;
				spm_d = pm_wdata_o;
			end
			@(posedge clk_i);
			#1;
			c++;
		end
		chk(nm, 24'h1, done_o);
		if (n > 0) chk(nm, 24'(n + 1), 24'(c));
	endtask
	task automatic ld_case(input lsiu_mode_t m, input lsiu_ptr_t p,
		input logic [4:0] lo, input logic [15:0] p0, ea, ep, input int n);
		logic [7:0] v;
		setp(lo, p0);
		run(mk(K_LOAD, m, p, 5'h05, ea - p0), n, "load");
		rreg(5'h05, v);
		chk("load data", {16'h0, ea[7:0] ^ 8'hA5}, v);
		getp(lo, ep);
	endtask
	task automatic st_case(input lsiu_kind_t k, input lsiu_mode_t m,
		input lsiu_ptr_t p, input logic [4:0] lo,
		input logic [15:0] p0, imm, ep, input logic [7:0] v, input int n);
		setp(lo, p0);
		wreg(5'h08, v);
		run(mk(k, m, p, 5'h08, imm), n, "store");
		getp(lo, ep);
	endtask
	task automatic t_load();
		ld_case(M_POSTINC, P_X, PTR_X_LO, 16'h00FF, 16'h00FF, 16'h0100, 1);
		ld_case(M_PREDEC, P_Y, PTR_Y_LO, 16'h0020, 16'h001F, 16'h001F, 2);
		ld_case(M_PREDEC, P_Z, PTR_Z_LO, 16'h0100, 16'h00FF, 16'h00FF, 2);
		ld_case(M_DISP, P_Z, PTR_Z_LO, 16'h0030, 16'h006F, 16'h0030, 2);
		ld_case(M_PLAIN, P_Y, PTR_Y_LO, 16'h0050, 16'h0050, 16'h0050, 1);
		instr_i = mk(K_LOAD, M_DISP, P_X, 5'h05, 16'h0003);
		instr_valid_i = 1'b1;
		@(posedge clk_i);
		#1;
		instr_valid_i = 1'b0;
		chk("refused", 24'h6, {illegal_o, ready_o, dm_rd_o});
	endtask
	task automatic t_store();
		logic [15:0] a [5] = '{16'h0040, 16'h0041, 16'h0043, 16'h0046, 16'h0047};
		logic [7:0] v;
		st_case(K_DIRECT_ST, M_PLAIN, P_X, PTR_X_LO, 0, 16'h0040, 0, 8'h31, 2);
		st_case(K_STORE, M_POSTINC, P_X, PTR_X_LO, 16'h0041, 0, 16'h0042, 8'h32, 1);
		st_case(K_STORE, M_PREDEC, P_Y, PTR_Y_LO, 16'h0044, 0, 16'h0043, 8'h33, 2);
		st_case(K_STORE, M_DISP, P_Y, PTR_Y_LO, 16'h0044, 2, 16'h0044, 8'h34, 2);
		st_case(K_STORE, M_PLAIN, P_Z, PTR_Z_LO, 16'h0047, 0, 16'h0047, 8'h35, 1);
		for (int i = 0; i < 5; i++) begin
			setp(PTR_X_LO, a[i]);
			run(mk(K_LOAD, M_PLAIN, P_X, 5'h09, 16'h0), 1, "read back");
			rreg(5'h09, v);
			chk("stored byte", 24'(8'h31 + i), v);
		end
	endtask
	task automatic t_pm();
		lsiu_instr_t i;
		logic [7:0] v;
		setp(PTR_Z_LO, 16'h0123);
		wreg(REG_ZERO, 8'hEE);
		i = mk(K_PM_LOAD, M_PLAIN, P_Z, 5'h0A, 16'h0);
		i.has_reg = 1'b0;
		run(i, 3, "pm load");
		rreg(REG_ZERO, v);
		chk("pm load r0", 24'h23 ^ 24'h3C, v);
		run(mk(K_PM_LOAD_EX, M_POSTINC, P_Z, 5'h0A, 16'h0), 3, "ext");
		rreg(5'h0A, v);
		chk("ext pm load", 24'h23 ^ 24'h02 ^ 24'h3C, v);
		getp(PTR_Z_LO, 16'h0124);
		wreg(REG_ZERO, 8'h11);
		wreg(REG_ONE, 8'h22);
		run(mk(K_PM_STORE, M_POSTINC, P_Z, 5'h00, 16'h0), 0, "spm slow");
		chk("spm addr", 24'h020124, spm_a);
		chk("spm data", 24'h2211, spm_d);
		getp(PTR_Z_LO, 16'h0126);
		ack_dly = 4'h0;
		run(mk(K_PM_STORE, M_PLAIN, P_Z, 5'h00, 16'h0), 0, "spm fast");
		chk("spm fast addr", 24'h020126, spm_a);
		getp(PTR_Z_LO, 16'h0126);
		run(mk(K_PM_LOAD, M_POSTINC, P_Z, 5'h0D, 16'h0), 3, "pm inc");
		rreg(5'h0D, v);
		chk("pm load rd", 24'h26 ^ 24'h3C, v);
		getp(PTR_Z_LO, 16'h0127);
	endtask
	task automatic t_io_stack();
		logic [7:0] v;
		wreg(5'h08, 8'h5C);
		run(mk(K_IO_OUT, M_PLAIN, P_X, 5'h08, 16'h0015), 1, "out");
		run(mk(K_IO_IN, M_PLAIN, P_X, 5'h0B, 16'h0015), 1, "in");
		rreg(5'h0B, v);
		chk("io in", 24'h5C, v);
		run(mk(K_PUSH, M_PLAIN, P_X, 5'h08, 16'h0), 1, "push");
		chk("sp push", 24'h3FFE, sp_o);
		run(mk(K_POP, M_PLAIN, P_X, 5'h0C, 16'h0), 2, "pop");
		rreg(5'h0C, v);
		chk("pop data", 24'h5C, v);
		chk("sp pop", 24'h3FFF, sp_o);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		instr_valid_i = 1'b0;
		instr_i = '0;
		page_i = 8'h02;
		reg_we_i = 1'b0;
		reg_waddr_i = 5'h00;
		reg_wdata_i = 8'h00;
		reg_raddr_i = 5'h00;
		ack_dly = 4'h4;
		repeat (20) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		chk("ready", 24'h1, ready_o);
		chk("sp", 24'h3FFF, sp_o);
		t_load();
		t_store();
		t_pm();
		t_io_stack();
		stop_test();
	end
	// the whole run needs well under a thousand clocks
	initial begin
		#50000;
		bad_count++;
		stop_test();
	end
endmodule // lsiu_core_tb_top
`default_nettype wire

/* bench/lsiu_mem_model.sv */
// lsiu_mem_model: data, program and io spaces facing the core
`timescale 1ns/10ps
`default_nettype none
module lsiu_mem_model
	import lsiu_pkg::*;
(
	input  wire logic			clk_i,
	input  wire logic			dm_rd_i,
	input  wire logic			dm_wr_i,
	input  wire logic [ADDR_W-1:0]		dm_addr_i,
	input  wire logic [7:0]			dm_wdata_i,
	output logic [7:0]			dm_rdata_o,
	input  wire logic			pm_rd_i,
	input  wire logic			pm_wr_i,
	input  wire logic [PM_ADDR_W-1:0]	pm_addr_i,
	output logic [7:0]			pm_rdata_o,
	output logic				pm_ack_o,
	input  wire logic [3:0]			ack_dly_i,
	input  wire logic			io_rd_i,
	input  wire logic			io_wr_i,
	input  wire logic [IO_ADDR_W-1:0]	io_addr_i,
	input  wire logic [7:0]			io_wdata_i,
	output logic [7:0]			io_rdata_o
);
	logic [7:0]	dmem [256];
	logic [7:0]	iomem [64];
	logic [7:0]	junk = 8'h5A;
	logic [3:0]	wait_cnt = 4'h0;
	initial begin
		for (int i = 0; i < 256; i++) begin
			dmem[i] = 8'(i) ^ 8'hA5;
		end
	end
	// released read lines never hold the last byte
	assign dm_rdata_o = dm_rd_i ? dmem[dm_addr_i[7:0]] : junk;
	assign io_rdata_o = io_rd_i ? iomem[io_addr_i] : ~junk;
	assign pm_rdata_o = pm_rd_i ?
		pm_addr_i[7:0] ^ pm_addr_i[23:16] ^ 8'h3C : junk;
	// zero delay answers at once, larger ones stall the core
	assign pm_ack_o = pm_wr_i && wait_cnt == ack_dly_i;
	always @(posedge clk_i) begin
		junk <= junk + 8'h3B;
		wait_cnt <= (pm_wr_i && !pm_ack_o) ? wait_cnt + 4'h1 : 4'h0;
		if (dm_wr_i) begin
			dmem[dm_addr_i[7:0]] <= dm_wdata_i;
		end
		if (io_wr_i) begin
			iomem[io_addr_i] <= io_wdata_i;
		end
	end
endmodule // lsiu_mem_model
`default_nettype wire

/* rtl/lsiu_addr_gen.sv */
// lsiu_addr_gen: effective address and pointer/stack updates
`timescale 1ns/10ps
`default_nettype none
module lsiu_addr_gen
	import lsiu_pkg::*;
(
	input  wire lsiu_instr_t  instr_i,
	input  wire logic [15:0]  ptr_i,
	input  wire logic [15:0]  sp_i,
	output logic      [15:0]  addr_o,
	output logic      [15:0]  ptr_next_o,
	output logic      [15:0]  sp_next_o
);

	always_comb begin
		addr_o     = ptr_i;
		ptr_next_o = ptr_i;
		sp_next_o  = sp_i;
		unique case (instr_i.kind)
			K_LOAD, K_STORE: begin
				unique case (instr_i.mode)
					M_POSTINC: ptr_next_o = ptr_i + 16'h0001;
					M_PREDEC: begin
						ptr_next_o = ptr_i - 16'h0001;
						addr_o     = ptr_i - 16'h0001;
					end
					M_DISP:  addr_o = ptr_i + {10'h000, instr_i.disp};
					M_PLAIN: addr_o = ptr_i;
				endcase
			end
			K_DIRECT_ST: addr_o = instr_i.imm;
			K_PM_LOAD, K_PM_LOAD_EX: begin
				if (instr_i.mode == M_POSTINC) begin
					ptr_next_o = ptr_i + 16'h0001;
				end
			end
			K_PM_STORE: begin
				if (instr_i.mode == M_POSTINC) begin
					ptr_next_o = ptr_i + 16'h0002;
				end
			end
			K_PUSH: begin
				addr_o    = sp_i;
				sp_next_o = sp_i - 16'h0001;
			end
			K_POP: begin
				addr_o    = sp_i + 16'h0001;
				sp_next_o = sp_i + 16'h0001;
			end
			default: begin
				addr_o = ptr_i;
			end
		endcase
	end

endmodule // lsiu_addr_gen
`default_nettype wire

/* rtl/lsiu_core.sv */
// lsiu_core: data-transfer execution unit with its register file
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - a post-increment load reads the byte at the pointer, then adds one to it, in one clock.
// - a pre-decrement load subtracts one from the pointer first, then reads there, in two clocks.
// - a displacement load through the second or third pointer reads pointer plus offset, pointer kept, in two clocks.
// - a direct store writes the source register to the immediate address in two clocks.
// - a post-increment store writes at the pointer, then adds one to it, in one clock.
// - a pre-decrement store subtracts one from the pointer first, then writes there, in two clocks.
// - a displacement store through the second or third pointer writes at pointer plus offset, pointer kept, in two clocks.
// - a program-memory load reads the byte at the third pointer into register zero or the named one, optional post-increment, in three clocks.
// - the extended program-memory load puts the page extension above the third pointer, otherwise as the plain one, in three clocks.
// - a program-memory store writes register one:zero at page:third pointer, post-increment adds two, no fixed time.
// - the I/O input and output instructions move a byte between a register and an I/O location in one clock each.
// - a push stores the source on the stack in one clock, a pop fetches the top into a register in two clocks.
module lsiu_core
	import lsiu_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// instruction from the decoder
	input  wire logic                 instr_valid_i,
	input  wire lsiu_instr_t          instr_i,
	output logic                      ready_o,
	output logic                      done_o,
	output logic                      illegal_o,
	// program page extension, held elsewhere in the core
	input  wire logic [7:0]           page_i,
	// register file side port for the rest of the core
	input  wire logic                 reg_we_i,
	input  wire logic [4:0]           reg_waddr_i,
	input  wire logic [7:0]           reg_wdata_i,
	input  wire logic [4:0]           reg_raddr_i,
	output logic      [7:0]           reg_rdata_o,
	output logic      [15:0]          sp_o,
	// data space
	output logic                      dm_rd_o,
	output logic                      dm_wr_o,
	output logic      [ADDR_W-1:0]    dm_addr_o,
	output logic      [7:0]           dm_wdata_o,
	input  wire logic [7:0]           dm_rdata_i,
	// program memory
	output logic                      pm_rd_o,
	output logic                      pm_wr_o,
	output logic      [PM_ADDR_W-1:0] pm_addr_o,
	output logic      [15:0]          pm_wdata_o,
	input  wire logic [7:0]           pm_rdata_i,
	input  wire logic                 pm_ack_i,
	// I/O space
	output logic                      io_rd_o,
	output logic                      io_wr_o,
	output logic      [IO_ADDR_W-1:0] io_addr_o,
	output logic      [7:0]           io_wdata_o,
	input  wire logic [7:0]           io_rdata_i
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_WAIT = 3'b010,
		S_ACC  = 3'b100
	} lsiu_state_t;

	lsiu_state_t state_reg;
	lsiu_state_t state_next;
	logic [7:0]  rf_reg [REG_NUM];
	logic [15:0] sp_reg;
	logic [1:0]  cnt_reg;
	lsiu_kind_t  kind_reg;
	logic [4:0]  dest_reg;

	lsiu_instr_t ins;
	logic [4:0]  ptr_lo;
	logic [15:0] ptr_val;
	logic [15:0] eff_addr;
	logic [15:0] ptr_new;
	logic [15:0] sp_new;
	logic        legal;
	logic        take;
	logic        go_acc;
	logic        acc_end;
	logic        writes_ptr;

	// ----------------------------------------------------------------
	// decode of the offered instruction
	// ----------------------------------------------------------------
	always_comb begin
		ins = instr_i;
		if (instr_i.kind == K_PM_LOAD || instr_i.kind == K_PM_LOAD_EX ||
			instr_i.kind == K_PM_STORE) begin
			ins.ptr = P_Z;
		end
		if ((instr_i.kind == K_PM_LOAD || instr_i.kind == K_PM_LOAD_EX) &&
			!instr_i.has_reg) begin
			ins.regno = REG_ZERO;
		end
	end

	// displacement only on the second and third pointers
	always_comb begin
		legal = 1'b1;
		if ((ins.kind == K_LOAD || ins.kind == K_STORE) &&
			ins.mode == M_DISP && ins.ptr == P_X) begin
			legal = 1'b0;
		end
		if ((ins.kind == K_PM_LOAD || ins.kind == K_PM_LOAD_EX ||
			ins.kind == K_PM_STORE) &&
			(ins.mode == M_PREDEC || ins.mode == M_DISP)) begin
			legal = 1'b0;
		end
		if (ins.kind > K_POP) begin
			legal = 1'b0;
		end
	end

	assign ptr_lo  = lsiu_ptr_lo(ins.ptr);
	assign ptr_val = {rf_reg[ptr_lo + 5'h01], rf_reg[ptr_lo]};
	assign take    = (state_reg == S_IDLE) && instr_valid_i && legal;

	assign writes_ptr = (ins.kind == K_LOAD || ins.kind == K_STORE ||
		ins.kind == K_PM_LOAD || ins.kind == K_PM_LOAD_EX ||
		ins.kind == K_PM_STORE);

	lsiu_addr_gen u_addr_gen (
		.instr_i    (ins),
		.ptr_i      (ptr_val),
		.sp_i       (sp_reg),
		.addr_o     (eff_addr),
		.ptr_next_o (ptr_new),
		.sp_next_o  (sp_new)
	);

	// ----------------------------------------------------------------
	// sequencing: the instruction holds ready low for its clock count, a program memory store until the memory acknowledges
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		go_acc     = 1'b0;
		acc_end    = 1'b0;
		unique case (state_reg)
			S_IDLE: begin
				if (take) begin
					go_acc     = (lsiu_clocks(ins) == CLK_ONE);
					state_next = go_acc ? S_ACC : S_WAIT;
				end
			end
			S_WAIT: begin
				if (cnt_reg == CLK_ONE) begin
					go_acc     = 1'b1;
					state_next = S_ACC;
				end
			end
			S_ACC: begin
				// program memory store lasts until the memory acknowledges
				if (kind_reg != K_PM_STORE || pm_ack_i) begin
					acc_end    = 1'b1;
					state_next = S_IDLE;
				end
			end
			default: state_next = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= S_IDLE;
			cnt_reg   <= 2'h0;
			kind_reg  <= K_LOAD;
			dest_reg  <= REG_ZERO;
		end else begin
			state_reg <= state_next;
			if (take) begin
				cnt_reg  <= lsiu_clocks(ins) - CLK_ONE;
				kind_reg <= ins.kind;
				dest_reg <= ins.regno;
			end else if (state_reg == S_WAIT) begin
				cnt_reg <= cnt_reg - CLK_ONE;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ready_o   <= 1'b1;
			done_o    <= 1'b0;
			illegal_o <= 1'b0;
		end else begin
			ready_o   <= (state_next == S_IDLE);
			done_o    <= acc_end;
			illegal_o <= (state_reg == S_IDLE) && instr_valid_i && !legal;
		end
	end

	// ----------------------------------------------------------------
	// memory strobes, launched for the last clock of the instruction
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dm_rd_o    <= 1'b0;
			dm_wr_o    <= 1'b0;
			dm_addr_o  <= 16'h0000;
			dm_wdata_o <= 8'h00;
			pm_rd_o    <= 1'b0;
			pm_wr_o    <= 1'b0;
			pm_addr_o  <= 24'h000000;
			pm_wdata_o <= 16'h0000;
			io_rd_o    <= 1'b0;
			io_wr_o    <= 1'b0;
			io_addr_o  <= 6'h00;
			io_wdata_o <= 8'h00;
		end else begin
			if (take) begin
				dm_addr_o  <= eff_addr;
				dm_wdata_o <= rf_reg[ins.regno];
				pm_addr_o  <= (ins.kind == K_PM_LOAD)
					? {PM_PAGE_ZERO, ptr_val}
					: {page_i, ptr_val};
				pm_wdata_o <= {rf_reg[REG_ONE], rf_reg[REG_ZERO]};
				io_addr_o  <= ins.io_addr;
				io_wdata_o <= rf_reg[ins.regno];
			end
			if (go_acc) begin
				dm_rd_o <= (kind_reg == K_LOAD || kind_reg == K_POP) && !take ||
					take && (ins.kind == K_LOAD);
				dm_wr_o <= take ? (ins.kind == K_STORE || ins.kind == K_PUSH)
					: (kind_reg == K_STORE || kind_reg == K_DIRECT_ST);
				pm_rd_o <= !take &&
					(kind_reg == K_PM_LOAD || kind_reg == K_PM_LOAD_EX);
				pm_wr_o <= take && (ins.kind == K_PM_STORE);
				io_rd_o <= take && (ins.kind == K_IO_IN);
				io_wr_o <= take && (ins.kind == K_IO_OUT);
			end else if (acc_end) begin
				dm_rd_o <= 1'b0;
				dm_wr_o <= 1'b0;
				pm_rd_o <= 1'b0;
				pm_wr_o <= 1'b0;
				io_rd_o <= 1'b0;
				io_wr_o <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// register file and stack pointer
	// ----------------------------------------------------------------
	// no status register is touched anywhere below
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < REG_NUM; i++) begin
				rf_reg[i] <= REG_RESET;
			end
		end else begin
			if (reg_we_i) begin
				rf_reg[reg_waddr_i] <= reg_wdata_i;
			end
			// pointer moves at issue; the strobe already holds the old address
			if (take && writes_ptr) begin
				rf_reg[ptr_lo]          <= ptr_new[7:0];
				rf_reg[ptr_lo + 5'h01]  <= ptr_new[15:8];
			end
			if (acc_end) begin
				unique case (kind_reg)
					K_LOAD, K_POP: rf_reg[dest_reg] <= dm_rdata_i;
					K_PM_LOAD, K_PM_LOAD_EX:
						rf_reg[dest_reg] <= pm_rdata_i;
					K_IO_IN:       rf_reg[dest_reg] <= io_rdata_i;
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sp_reg <= SP_RESET;
		end else if (take && (ins.kind == K_PUSH || ins.kind == K_POP)) begin
			sp_reg <= sp_new;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= REG_RESET;
			sp_o        <= SP_RESET;
		end else begin
			reg_rdata_o <= rf_reg[reg_raddr_i];
			sp_o        <= sp_reg;
		end
	end

endmodule // lsiu_core
`default_nettype wire

/* rtl/lsiu_pkg.sv */
// lsiu_pkg: shared types and constants of the load/store instruction unit
package lsiu_pkg;

	// ----------------------------------------------------------------
	// widths and register indices
	// ----------------------------------------------------------------
	localparam int          DATA_W     = 8;
	localparam int          ADDR_W     = 16;
	localparam int          PM_ADDR_W  = 24;
	localparam int          IO_ADDR_W  = 6;
	localparam int          DISP_W     = 6;
	localparam int          REG_NUM    = 32;
	localparam logic [4:0]  REG_ZERO   = 5'h00;
	localparam logic [4:0]  REG_ONE    = 5'h01;
	localparam logic [4:0]  PTR_X_LO   = 5'h1A;
	localparam logic [4:0]  PTR_Y_LO   = 5'h1C;
	localparam logic [4:0]  PTR_Z_LO   = 5'h1E;
	localparam logic [15:0] SP_RESET   = 16'h3FFF;
	localparam logic [7:0]  REG_RESET  = 8'h00;
	localparam logic [7:0]  PM_PAGE_ZERO = 8'h00;

	// ----------------------------------------------------------------
	// cycle counts, in clocks of the core
	// ----------------------------------------------------------------
	localparam logic [1:0]  CLK_ONE    = 2'h1;
	localparam logic [1:0]  CLK_TWO    = 2'h2;
	localparam logic [1:0]  CLK_THREE  = 2'h3;

	// ----------------------------------------------------------------
	// instruction encoding
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		K_LOAD       = 4'h0,
		K_STORE      = 4'h1,
		K_DIRECT_ST  = 4'h2,
		K_PM_LOAD    = 4'h3,
		K_PM_LOAD_EX = 4'h4,
		K_PM_STORE   = 4'h5,
		K_IO_IN      = 4'h6,
		K_IO_OUT     = 4'h7,
		K_PUSH       = 4'h8,
		K_POP        = 4'h9
	} lsiu_kind_t;

	typedef enum logic [1:0] {
		M_PLAIN   = 2'h0,
		M_POSTINC = 2'h1,
		M_PREDEC  = 2'h2,
		M_DISP    = 2'h3
	} lsiu_mode_t;

	typedef enum logic [1:0] {
		P_X = 2'h0,
		P_Y = 2'h1,
		P_Z = 2'h2
	} lsiu_ptr_t;

	typedef struct packed {
		lsiu_kind_t           kind;
		lsiu_mode_t           mode;
		lsiu_ptr_t            ptr;
		logic                 has_reg;
		logic [4:0]           regno;
		logic [DISP_W-1:0]    disp;
		logic [ADDR_W-1:0]    imm;
		logic [IO_ADDR_W-1:0] io_addr;
	} lsiu_instr_t;

	// low register of a pointer pair
	function automatic logic [4:0] lsiu_ptr_lo(input lsiu_ptr_t p);
		unique case (p)
			P_X:     lsiu_ptr_lo = PTR_X_LO;
			P_Y:     lsiu_ptr_lo = PTR_Y_LO;
			default: lsiu_ptr_lo = PTR_Z_LO;
		endcase
	endfunction

	// clocks an instruction occupies; store to program memory waits on ack
	function automatic logic [1:0] lsiu_clocks(input lsiu_instr_t i);
		unique case (i.kind)
			K_LOAD, K_STORE:
				lsiu_clocks = (i.mode == M_PREDEC || i.mode == M_DISP)
					? CLK_TWO : CLK_ONE;
			K_DIRECT_ST, K_POP:        lsiu_clocks = CLK_TWO;
			K_PM_LOAD, K_PM_LOAD_EX:   lsiu_clocks = CLK_THREE;
			default:                   lsiu_clocks = CLK_ONE;
		endcase
	endfunction

endpackage
